// *** design/sram_tap.sv ***
// Purpose: Boundary-scan port of the SRAM with output bus tristate cell
// Assumes: Link clock, mode select and serial in are pins, so synced
// Notes:   Link clock edges found by sampling at core_clk_i
`timescale 1ns/1ps
`include "sram_tap_defines.svh"

module sram_tap
    import sram_tap_pkg::*;
#(
    parameter int                  BSR_LEN  = `BSR_LEN_165,
    parameter logic [BSR_LEN-1:0]  NC_MASK  = '0,
    // Arbitrary revision, device and vendor values, not a real part's
    parameter logic [2:0]          REV_ID   = 3'h3,
    parameter logic [16:0]         DEV_ID   = 17'h0ABCD,
    parameter logic [10:0]         VEND_ID  = 11'h155
)(
    input  wire logic               core_clk_i,
    input  wire logic               rst_i,
    input  wire logic               tck_i,
    input  wire logic               tms_i,
    input  wire logic               tdi_i,
    input  wire logic [BSR_LEN-1:0] io_ring_i,
    input  wire logic               sram_q_oe_i,
    output logic                    tdo_o,
    output logic                    tdo_oe_o,
    output logic                    q_oe_o,
    output logic                    extest_o,
    output logic [BSR_LEN-1:0]      bsr_update_o,
    output logic [`IR_WIDTH-1:0]    instr_o,
    output logic                    tap_reset_o
);

    // ************************************************************
    // Local constants
    // ************************************************************
    localparam int TRI_IDX = BSR_LEN - 1;
    localparam logic [BSR_LEN-1:0] BSR_PRESET =
        {1'b1, {(BSR_LEN-1){1'b0}}};
    localparam logic [`ID_WIDTH-1:0] ID_BASE = {REV_ID, DEV_ID, VEND_ID,
                                                1'b1};
    localparam logic [`ID_WIDTH-1:0] ID_CODE =
        ID_BASE | (`ID_WIDTH'(1) << `ID_FIXED_BIT);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic               tck_m_q;
    logic               tck_s_q;
    logic               tck_p_q;
    logic               tms_m_q;
    logic               tms_s_q;
    logic               tdi_m_q;
    logic               tdi_s_q;
    logic [BSR_LEN-1:0] ring_m_q;
    logic [BSR_LEN-1:0] ring_s_q;
    logic               qoe_m_q;
    logic               qoe_s_q;
    logic               tck_rise;
    logic               tck_fall;

    // Two flops on every pin input, then an edge history flop on the link clock only
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tck_m_q  <= 1'b0;
            tck_s_q  <= 1'b0;
            tck_p_q  <= 1'b0;
            tms_m_q  <= 1'b1;
            tms_s_q  <= 1'b1;
            tdi_m_q  <= 1'b1;
            tdi_s_q  <= 1'b1;
            ring_m_q <= '0;
            ring_s_q <= '0;
            qoe_m_q  <= 1'b0;
            qoe_s_q  <= 1'b0;
        end else begin
            tck_m_q  <= tck_i;
            tck_s_q  <= tck_m_q;
            tck_p_q  <= tck_s_q;
            tms_m_q  <= tms_i;
            tms_s_q  <= tms_m_q;
            tdi_m_q  <= tdi_i;
            tdi_s_q  <= tdi_m_q;
            ring_m_q <= io_ring_i;
            ring_s_q <= ring_m_q;
            qoe_m_q  <= sram_q_oe_i;
            qoe_s_q  <= qoe_m_q;
        end
    end

    // Link clock edge enables
    assign tck_rise = tck_s_q & ~tck_p_q;
    assign tck_fall = ~tck_s_q & tck_p_q;

    // ************************************************************
    // Controller
    // ************************************************************
    tap_state_t state;

    tap_state_ctrl u_ctrl (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .tck_rise_i (tck_rise),
        .tms_i      (tms_s_q),
        .state_o    (state)
    );

    // ************************************************************
    // Instruction register
    // ************************************************************
    logic [`IR_WIDTH-1:0] ir_sr_q;
    instr_t               ir_q;

    // Shift stage: capture 01 pattern, shift from MSB
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ir_sr_q <= `IR_CAPTURE_VAL;
        end else if (tck_rise) begin
            if (state == ST_CAP_IR) begin
                ir_sr_q <= `IR_CAPTURE_VAL;
            end else if (state == ST_SHIFT_IR) begin
                ir_sr_q <= {tdi_s_q, ir_sr_q[`IR_WIDTH-1:1]};
            end
        end
    end

    // Current instruction, IDCODE at once on entering reset state
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ir_q <= INS_IDCODE;
        end else if (state == ST_TLR) begin
            ir_q <= INS_IDCODE;
        end else if (tck_rise && state == ST_UPD_IR) begin
            ir_q <= instr_t'(ir_sr_q);
        end
    end

    // ************************************************************
    // Data register selection
    // ************************************************************
    logic sel_bsr;
    logic sel_id;

    // Reserved codes fall through to bypass
    always_comb begin
        sel_bsr = 1'b0;
        sel_id  = 1'b0;
        unique case (ir_q)
            INS_EXTEST:  sel_bsr = 1'b1;
            INS_SAMPLEZ: sel_bsr = 1'b1;
            INS_PRELOAD: sel_bsr = 1'b1;
            INS_IDCODE:  sel_id  = 1'b1;
            INS_BYPASS,
            INS_RSV3,
            INS_RSV5,
            INS_RSV6:    sel_bsr = 1'b0;
        endcase
    end

    // ************************************************************
    // Data registers
    // ************************************************************
    logic [BSR_LEN-1:0]   bsr_sr_q;
    logic [BSR_LEN-1:0]   bsr_upd_q;
    logic [`ID_WIDTH-1:0] id_sr_q;
    logic                 byp_q;
    logic [BSR_LEN-1:0]   ring_cap;

    // Captured ring: unconnected cells zero, control cell its latch
    always_comb begin
        ring_cap          = ring_s_q & ~NC_MASK;
        ring_cap[TRI_IDX] = bsr_upd_q[TRI_IDX];
    end

    // Scan chain shift stage of 85 or 89 cells
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bsr_sr_q <= BSR_PRESET;
        end else if (tck_rise && sel_bsr) begin
            if (state == ST_CAP_DR) begin
                bsr_sr_q <= ring_cap;
            end else if (state == ST_SHIFT_DR) begin
                bsr_sr_q <= {tdi_s_q, bsr_sr_q[BSR_LEN-1:1]};
            end
        end
    end

    // Preload latch, control cell preset high, others low
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bsr_upd_q <= BSR_PRESET;
        end else if (state == ST_TLR) begin
            bsr_upd_q <= BSR_PRESET;
        end else if (tck_rise && state == ST_UPD_DR && sel_bsr) begin
            bsr_upd_q <= bsr_sr_q & ~NC_MASK;
        end
    end

    // Identification shift stage with fixed fields
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            id_sr_q <= ID_CODE;
        end else if (tck_rise && sel_id) begin
            if (state == ST_CAP_DR) begin
                id_sr_q <= ID_CODE;
            end else if (state == ST_SHIFT_DR) begin
                id_sr_q <= {tdi_s_q, id_sr_q[`ID_WIDTH-1:1]};
            end
        end
    end

    // Single bypass bit, zero on capture
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            byp_q <= `BYPASS_CAPTURE;
        end else if (tck_rise && !sel_bsr && !sel_id) begin
            if (state == ST_CAP_DR) begin
                byp_q <= `BYPASS_CAPTURE;
            end else if (state == ST_SHIFT_DR) begin
                byp_q <= tdi_s_q;
            end
        end
    end

    // ************************************************************
    // Serial out on falling link clock
    // ************************************************************
    logic tdo_d;

    // Least significant bit of the selected register
    always_comb begin
        if (state == ST_SHIFT_IR) begin
            tdo_d = ir_sr_q[0];
        end else if (sel_bsr) begin
            tdo_d = bsr_sr_q[0];
        end else if (sel_id) begin
            tdo_d = id_sr_q[0];
        end else begin
            tdo_d = byp_q;
        end
    end

    // Update only on fall; driven only while shifting
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_o    <= tdo_d;
            tdo_oe_o <= (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
        end
    end

    // ************************************************************
    // SRAM output drivers
    // ************************************************************
    // Output enable follows instruction; latch governs in EXTEST
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_oe_o   <= 1'b0;
            extest_o <= 1'b0;
        end else begin
            extest_o <= (ir_q == INS_EXTEST);
            unique case (ir_q)
                INS_EXTEST:  q_oe_o <= bsr_upd_q[TRI_IDX];
                INS_SAMPLEZ: q_oe_o <= 1'b0;
                default:     q_oe_o <= qoe_s_q;
            endcase
        end
    end

    // Preload data, instruction and reset state to the core
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bsr_update_o <= BSR_PRESET;
            instr_o      <= `IR_CODE_IDCODE;
            tap_reset_o  <= 1'b1;
        end else begin
            bsr_update_o <= bsr_upd_q;
            instr_o      <= ir_q;
            tap_reset_o  <= (state == ST_TLR);
        end
    end

endmodule

// *** design/sram_tap_defines.svh ***
// Purpose: Constants of the boundary-scan port of the SRAM
// Assumes: Included by the package and the design modules
// Notes:   Definitions only, no logic
`ifndef SRAM_TAP_DEFINES_SVH
`define SRAM_TAP_DEFINES_SVH

// ****************************************************************
// Instruction register
// ****************************************************************
`define IR_WIDTH        3
`define IR_CODE_EXTEST  3'h0
`define IR_CODE_IDCODE  3'h1
`define IR_CODE_SAMPLEZ 3'h2
`define IR_CODE_RSV3    3'h3
`define IR_CODE_PRELOAD 3'h4
`define IR_CODE_RSV5    3'h5
`define IR_CODE_RSV6    3'h6
`define IR_CODE_BYPASS  3'h7
`define IR_CAPTURE_VAL  3'h1

// ****************************************************************
// Identification register layout
// ****************************************************************
`define ID_WIDTH        32
`define ID_REV_MSB      31
`define ID_REV_LSB      29
`define ID_DEV_MSB      28
`define ID_DEV_LSB      12
`define ID_VEND_MSB     11
`define ID_VEND_LSB     1
`define ID_PRESENT_BIT  0
`define ID_FIXED_BIT    24

// ****************************************************************
// Boundary scan lengths and presets
// ****************************************************************
`define BSR_LEN_119     85
`define BSR_LEN_165     89
`define BSR_LEN_MAX     89
`define BYPASS_CAPTURE  1'b0

// ****************************************************************
// Timing
// ****************************************************************
`define TMS_RESET_EDGES 5

`endif

// *** design/sram_tap_pkg.sv ***
// Purpose: Types of the boundary-scan port of the SRAM
// Assumes: sram_tap_defines.svh holds the numbers
// Notes:   One-hot state codes written out
`include "sram_tap_defines.svh"

package sram_tap_pkg;

    // ************************************************************
    // Controller states
    // ************************************************************
    typedef enum logic [15:0] {
        ST_TLR      = 16'h0001,
        ST_IDLE     = 16'h0002,
        ST_SEL_DR   = 16'h0004,
        ST_CAP_DR   = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR   = 16'h0100,
        ST_SEL_IR   = 16'h0200,
        ST_CAP_IR   = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR   = 16'h8000
    } tap_state_t;

    // ************************************************************
    // Instructions
    // ************************************************************
    typedef enum logic [`IR_WIDTH-1:0] {
        INS_EXTEST  = `IR_CODE_EXTEST,
        INS_IDCODE  = `IR_CODE_IDCODE,
        INS_SAMPLEZ = `IR_CODE_SAMPLEZ,
        INS_RSV3    = `IR_CODE_RSV3,
        INS_PRELOAD = `IR_CODE_PRELOAD,
        INS_RSV5    = `IR_CODE_RSV5,
        INS_RSV6    = `IR_CODE_RSV6,
        INS_BYPASS  = `IR_CODE_BYPASS
    } instr_t;

endpackage

// *** design/tap_state_ctrl.sv ***
// Purpose: Sixteen-state test access port controller
// Assumes: tck_rise_i is a one-cycle enable at each link clock rise
// Notes:   Steps only on enables; held in reset state by rst_i
`timescale 1ns/1ps
`include "sram_tap_defines.svh"

module tap_state_ctrl
    import sram_tap_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic tck_rise_i,
    input  wire logic tms_i,
    output tap_state_t state_o
);

    tap_state_t state_q;
    tap_state_t state_d;

    // Next state from mode select
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_TLR:      state_d = tms_i ? ST_TLR      : ST_IDLE;
            ST_IDLE:     state_d = tms_i ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   state_d = tms_i ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   state_d = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tms_i ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tms_i ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tms_i ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   state_d = tms_i ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   state_d = tms_i ? ST_TLR      : ST_CAP_IR;
            ST_CAP_IR:   state_d = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tms_i ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tms_i ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tms_i ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   state_d = tms_i ? ST_SEL_DR   : ST_IDLE;
            default:     state_d = ST_TLR;
        endcase
    end

    // State register, power-up into reset state
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_TLR;
        end else if (tck_rise_i) begin
            state_q <= state_d;
        end
    end

    assign state_o = state_q;

endmodule

// *** test/sram_tap_asserts.sv ***
// Purpose: Assertions on the boundary-scan port pins
// Assumes: Bound to sram_tap, one clock domain
// Notes:   Link clock edges found by sampling tck_i
`timescale 1ns/1ps
module sram_tap_asserts
    import sram_tap_pkg::*;
#(
    parameter int                 BSR_LEN = 89,
    parameter logic [BSR_LEN-1:0] NC_MASK = '0
)(
    input wire logic               core_clk_i,
    input wire logic               rst_i,
    input wire logic               tck_i,
    input wire logic               tms_i,
    input wire logic               sram_q_oe_i,
    input wire logic               tdo_o,
    input wire logic               tdo_oe_o,
    input wire logic               q_oe_o,
    input wire logic               extest_o,
    input wire logic [BSR_LEN-1:0] bsr_update_o,
    input wire logic [2:0]         instr_o,
    input wire logic               tap_reset_o
);
    // ****
    // Helpers
    // ****
    logic [2:0] up_q;
    logic [2:0] hi_q;

    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    // Cycles since reset, saturating
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            up_q <= 3'h0;
        end else if (up_q != 3'h7) begin
            up_q <= up_q + 3'h1;
        end
    end

    // Link rises in a row with mode select high
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hi_q <= 3'h0;
        end else if ($rose(tck_i)) begin
            hi_q <= !tms_i ? 3'h0 : (hi_q == 3'h7) ? hi_q : hi_q + 3'h1;
        end
    end

    // ****
    // Properties
    // ****
    a_tdo_on_fall: assert property (
        $changed(tdo_o) |-> !$past(tck_i)) else $error("tdo moved, tck high");
    a_tdo_off_reset: assert property (
        tap_reset_o |-> !tdo_oe_o) else $error("tdo driven in reset");
    a_reset_loads_id: assert property (
        tap_reset_o && $past(tap_reset_o) |-> instr_o == INS_IDCODE
        && bsr_update_o[BSR_LEN-1]) else $error("reset state values");
    a_samplez_hiz: assert property (
        instr_o == INS_SAMPLEZ |-> !q_oe_o) else $error("sample z drive");
    a_extest_cell: assert property (
        instr_o == INS_EXTEST |-> q_oe_o ==
        bsr_update_o[BSR_LEN-1]) else $error("extest driver enable");
    a_normal_oe: assert property (
        up_q == 3'h7 && instr_o != INS_EXTEST
        && instr_o != INS_SAMPLEZ && $stable(sram_q_oe_i)
        && $past(sram_q_oe_i, 2) == sram_q_oe_i
        && $past(sram_q_oe_i, 3) == sram_q_oe_i |-> q_oe_o == sram_q_oe_i)
        else $error("sram driver disturbed");
    a_extest_flag: assert property (
        instr_o == INS_EXTEST && $past(instr_o) == INS_EXTEST |-> extest_o)
        else $error("extest flag low");
    a_open_balls_low: assert property (
        (bsr_update_o & NC_MASK) == '0) else $error("open ball cell set");
    a_five_highs: assert property (
        $rose(tck_i) && tms_i && hi_q == 3'h4 |-> ##[1:6] tap_reset_o)
        else $error("no reset after five highs");
endmodule

bind sram_tap sram_tap_asserts #(
    .BSR_LEN (BSR_LEN),
    .NC_MASK (NC_MASK)
) i_sram_tap_asserts (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .tck_i        (tck_i),
    .tms_i        (tms_i),
    .sram_q_oe_i  (sram_q_oe_i),
    .tdo_o        (tdo_o),
    .tdo_oe_o     (tdo_oe_o),
    .q_oe_o       (q_oe_o),
    .extest_o     (extest_o),
    .bsr_update_o (bsr_update_o),
    .instr_o      (instr_o),
    .tap_reset_o  (tap_reset_o)
);

// *** test/jtag_ctrl_model.sv ***
// Purpose: Behavioural test controller on the link pins
// Assumes: Tasks are called at a core clock falling edge
// Notes:   Link clock stands low outside frames
`timescale 1ns/1ps
module jtag_ctrl_model (
    input  wire logic core_clk_i,
    input  wire logic tdo_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o
);
    // ****
    // Link steps
    // ****
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // One link clock, low then high for 4 core cycles each
    task automatic step(input logic ms, input logic di, output logic q);
        tms_o = ms;
        tdi_o = di;
        repeat (4) @(negedge core_clk_i);
        q = tdo_i;
        tck_o = 1'b1;
        repeat (4) @(negedge core_clk_i);
        tck_o = 1'b0;
    endtask

    // Five mode-select highs, then idle
    task automatic reset5();
        logic d;
        repeat (5) step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
    endtask

    // Idle, capture, shift n bits LSB first, update, idle
    task automatic scan(input logic ir, input int n,
                        input logic [127:0] din,
                        output logic [127:0] dout);
        logic d;
        dout = '0;
        step(1'b0, 1'b1, d);
        step(1'b1, 1'b1, d);
        if (ir) begin
            step(1'b1, 1'b1, d);
        end
        step(1'b0, 1'b1, d);
        step(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
    endtask
endmodule

// *** test/sram_tap_tb_top.sv ***
// Purpose: Self-checking bench of the boundary-scan port
// Assumes: Controller model drives the link at core falling edges
// Notes:   Random data from an LFSR that starts at 88
`timescale 1ns/1ps
module sram_tap_tb_top;
    // ****
    // Set-up
    // ****
    localparam int           N   = 89;
    localparam logic [N-1:0] NCM = (89'h1 << 5) | (89'h1 << 40);
    // Arbitrary identity values
    localparam logic [2:0]   REV = 3'h5;
    localparam logic [16:0]  DEV = 17'h0ABCD;
    localparam logic [10:0]  VEN = 11'h2A3;

    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         sqoe = 1'b1;
    logic [N-1:0] ring = '0;
    logic         tck, tms, tdi, tdo, tdo_oe, tdo_w, q_oe, ext, trst;
    logic [N-1:0] upd;
    logic [2:0]   ins;
    logic [127:0] si, so;
    logic [15:0]  rnd = 16'h0058;
    logic [2:0]   bc [4] = '{3'h7, 3'h7, 3'h7, 3'h7};
    int           err_total = 0;
    int           num_checks = 0;

    always #10 clk = ~clk;

    // Released serial out shows the inverse of its data
    assign tdo_w = tdo_oe ? tdo : ~tdo;

    sram_tap #(
        .BSR_LEN (N),
        .NC_MASK (NCM),
        .REV_ID  (REV),
        .DEV_ID  (DEV),
        .VEND_ID (VEN)
    ) i_sram_tap (
        .core_clk_i   (clk),
        .rst_i        (rst),
        .tck_i        (tck),
        .tms_i        (tms),
        .tdi_i        (tdi),
        .io_ring_i    (ring),
        .sram_q_oe_i  (sqoe),
        .tdo_o        (tdo),
        .tdo_oe_o     (tdo_oe),
        .q_oe_o       (q_oe),
        .extest_o     (ext),
        .bsr_update_o (upd),
        .instr_o      (ins),
        .tap_reset_o  (trst)
    );

    jtag_ctrl_model i_jtag_ctrl_model (
        .core_clk_i (clk),
        .tdo_i      (tdo_w),
        .tck_o      (tck),
        .tms_o      (tms),
        .tdi_o      (tdi)
    );

    // ****
    // Checking
    // ****
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // Expected capture: open balls low, tristate cell on top
    function automatic logic [N-1:0] cap(input logic top);
        return {top, ring[N-2:0] & ~NCM[N-2:0]};
    endfunction

    // Fresh random pattern
    task automatic fill();
        si = '0;
        repeat (8) begin
            repeat (16) rnd = lfsr(rnd);
            si = {si[111:0], rnd};
        end
    endtask

    task automatic chk(input logic [127:0] got, input logic [127:0] exp,
                       input string m);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Run limit
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        summarize();
    end

    // ****
    // Scenarios
    // ****
    initial begin
        fill();
        ring = si[N-1:0];
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk(ins, 3'h1, "ir reset");
        chk(upd, {1'b1, {(N-1){1'b0}}}, "latch preset");
        chk({trst, tdo_oe}, 2'b10, "reset state");
        i_jtag_ctrl_model.scan(1'b0, 32, si, so);
        chk(so[31:0], {REV, DEV | 17'h01000, VEN, 1'b1}, "id");
        // Bypass with fresh driver enables, legal codes only
        foreach (bc[k]) begin
            sqoe = rnd[3];
            i_jtag_ctrl_model.scan(1'b1, 3, {125'h0, bc[k]}, so);
            chk(so[2:0], 3'h1, "ir capture");
            chk(ins, bc[k], "ir load");
            fill();
            i_jtag_ctrl_model.scan(1'b0, 8, si, so);
            chk(so[7:0], {si[6:0], 1'b0}, "bypass");
            chk(q_oe, sqoe, "sram undisturbed");
        end
        // Preload a low tristate cell
        ring = si[N-1:0];
        i_jtag_ctrl_model.scan(1'b1, 3, 128'h4, so);
        fill();
        si[N-1] = 1'b0;
        i_jtag_ctrl_model.scan(1'b0, N, si, so);
        chk(so[N-1:0], cap(1'b1), "sample");
        chk(upd, si[N-1:0] & ~NCM, "preload");
        chk(q_oe, sqoe, "preload drive");
        // Extest follows the latched cell
        i_jtag_ctrl_model.scan(1'b1, 3, 128'h0, so);
        chk({ext, q_oe}, 2'b10, "extest off");
        fill();
        si[N+7] = 1'b1;
        i_jtag_ctrl_model.scan(1'b0, N + 8, si, so);
        chk(so[N+7:N], si[7:0], "chain length");
        chk(so[N-1:0], cap(1'b0), "extest capture");
        chk({upd, q_oe}, {si[N+7:8] & ~NCM, 1'b1}, "extest on");
        i_jtag_ctrl_model.scan(1'b1, 3, 128'h2, so);
        chk({ext, q_oe}, 2'b00, "sample z");
        i_jtag_ctrl_model.reset5();
        chk({ins, upd[N-1], q_oe}, {3'h1, 1'b1, sqoe}, "tms reset");
        summarize();
    end
endmodule
